// ---- brlq_bus_control.sv ----
/*
 * local bus control: bus cycle sequencer with read/write strobes and
 * address latch, ready handling with wait states, bus lock, and the
 * alternative queue status output mode chosen by a strap at reset.
 * assumes: the read strobe pin carries an external-or-internal pull-up
 * that holds it high while the output enable is low; the arbiter only
 * grants the bus while the sequencer is idle; the execution unit gives
 * one-cycle pulses for lock prefix and instruction completion.
 */
// Functional notes
// - queue codes: 00 none,01 first,11 next,10 flush
// - read strobe low only in read cycles
// - read strobe waits for floated address bus
// - read strobe released, pulled high during reset
// - strap sampled once after reset chooses mode
// - queue mode replaces latch and strobes
// - read strobe floats while bus granted away
// - async ready synchronised, accepted any time
// - async ready held high means always ready
// - sync ready sampled without synchroniser
// - sync ready path skips synchroniser delay
// - sync ready high always ready; unused low
// - lock output active low keeps masters off
// - lock starts at first data cycle
// - lock held until locked instruction ends
// - no prefetch cycles while lock asserted
// - lock floats in reset and bus grant
`timescale 1ns/1ns

module brlq_bus_control
    import brlq_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // bus cycle requests from the execution unit
    input wire logic req_valid,
    input wire brlq_bus_req_type req,
    output logic req_ready,
    output logic prefetch_blocked,
    output logic cycle_done,
    // lock and queue activity from the execution unit
    input wire logic lock_prefix_seen,
    input wire logic locked_instr_done,
    input wire brlq_queue_op_type queue_op,
    // arbitration: bus handed to another master
    input wire logic bus_granted,
    // board pins
    input wire logic read_strobe_mode_strap,
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    output brlq_pins_type pins,
    // mode chosen by the strap
    output logic queue_report_mode_select,
    output logic strap_captured
);

    // -------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_FLOAT,
        ST_DATA,
        ST_END
    } brlq_state_type;

    brlq_state_type state;
    brlq_state_type next_state;
    brlq_bus_req_type cur_req;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // map the execution unit's queue event to the pin code
    function automatic logic [1:0] queue_code(input brlq_queue_op_type op);
        case (op)
            QUEUE_FIRST_BYTE: queue_code = QUEUE_CODE_FIRST;
            QUEUE_NEXT_BYTE: queue_code = QUEUE_CODE_NEXT;
            QUEUE_EMPTIED: queue_code = QUEUE_CODE_FLUSH;
            default: queue_code = QUEUE_CODE_IDLE;
        endcase
    endfunction

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    logic strap_meta;
    logic strap_sync;
    logic async_ready_in_meta;
    logic async_ready_in_sync;

    // strap pin comes from the board, so two stages before use
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_meta <= STROBE_IDLE_LEVEL;
            strap_sync <= STROBE_IDLE_LEVEL;
        end else if (clk_en) begin
            strap_meta <= read_strobe_mode_strap;
            strap_sync <= strap_meta;
        end
    end

    // async ready synchroniser
    // a rising edge may land anywhere in the period; only the second stage is read
    always_ff @(posedge clk) begin
        if (reset) begin
            async_ready_in_meta <= 1'b0;
            async_ready_in_sync <= 1'b0;
        end else if (clk_en) begin
            async_ready_in_meta <= async_ready_in;
            async_ready_in_sync <= async_ready_in_meta;
        end
    end

    // -------------------------------------------------------------
    // strap capture
    // -------------------------------------------------------------
    logic [1:0] strap_count;

    // single strap sample
    // the count lets the pulled-up pin pass the synchroniser before the capture
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_count <= STRAP_COUNT_RESET;
            strap_captured <= 1'b0;
            queue_report_mode_select <= 1'b0;
        end else if (clk_en && !strap_captured) begin
            if (strap_count == 2'(STRAP_SETTLE_CYCLES - 1)) begin
                strap_captured <= 1'b1;
                queue_report_mode_select <= ~strap_sync;
            end else begin
                strap_count <= strap_count + 2'h1;
            end
        end
    end

    // -------------------------------------------------------------
    // ready combination
    // -------------------------------------------------------------
    // sync ready used directly
    // no synchroniser delay on sync path
    // either input held high is ready
    logic bus_ready;
    assign bus_ready = async_ready_in_sync | sync_ready_in;

    // -------------------------------------------------------------
    // lock tracking
    // -------------------------------------------------------------
    logic lock_armed;
    logic lock_active;
    logic start_cycle;
    logic take_req;

    // prefetches are refused while locked, data cycles always pass
    assign take_req = req_valid && req_ready && !(req.is_prefetch && lock_active);
    assign start_cycle = clk_en && state == ST_IDLE && take_req;

    // lock on first data cycle
    // the prefix arms the lock; the next non-prefetch cycle fires it
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_armed <= 1'b0;
        end else if (clk_en) begin
            if (lock_prefix_seen) begin
                lock_armed <= 1'b1;
            end else if (start_cycle && !req.is_prefetch) begin
                lock_armed <= 1'b0;
            end
        end
    end

    // hold lock until instruction ends
    // a new firing wins over a completion in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_active <= 1'b0;
        end else if (clk_en) begin
            if (start_cycle && !req.is_prefetch && lock_armed) begin
                lock_active <= 1'b1;
            end else if (locked_instr_done) begin
                lock_active <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // bus cycle sequencer
    // -------------------------------------------------------------
    // next state: address, float, data with waits, end
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_req) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: next_state = ST_FLOAT;
            ST_FLOAT: next_state = ST_DATA;
            ST_DATA: begin
                if (bus_ready) begin
                    next_state = ST_END;
                end
            end
            ST_END: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // state register and latched request
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
            cur_req <= '0;
        end else if (clk_en) begin
            state <= next_state;
            if (start_cycle) begin
                cur_req <= req;
            end
        end
    end

    // request handshake: accept only when idle, bus owned and mode known
    always_ff @(posedge clk) begin
        if (reset) begin
            req_ready <= 1'b0;
            prefetch_blocked <= 1'b0;
            cycle_done <= 1'b0;
        end else if (clk_en) begin
            req_ready <= next_state == ST_IDLE && !bus_granted && strap_captured && !start_cycle;
            prefetch_blocked <= lock_active || (start_cycle && !req.is_prefetch && lock_armed);
            cycle_done <= state == ST_DATA && bus_ready;
        end
    end

    // -------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------
    brlq_pins_type next_pins;
    logic reading;
    logic [1:0] qcode;

    assign reading = !cur_req.is_write;
    assign qcode = queue_code(queue_op);

    // next pin values; everything registers on the same edge
    always_comb begin
        next_pins = pins;
        // address bus driven in the address phase, and for writes in float and data
        next_pins.ad_oe = next_state == ST_ADDR ||
            (cur_req.is_write && (next_state == ST_FLOAT || next_state == ST_DATA));
        if (queue_report_mode_select) begin
            next_pins.ale_qs0 = qcode[0];
            next_pins.write_qs1 = qcode[1];
            next_pins.ale_qs0_oe = 1'b1;
            next_pins.write_qs1_oe = 1'b1;
            next_pins.read_strobe_n = STROBE_IDLE_LEVEL;
            next_pins.read_strobe_oe = 1'b0;
        end else begin
            next_pins.ale_qs0 = next_state == ST_ADDR;
            next_pins.write_qs1 = !(cur_req.is_write && next_state == ST_DATA);
            next_pins.ale_qs0_oe = strap_captured;
            next_pins.write_qs1_oe = strap_captured;
            // strobe after bus floated
            // the strobe may fall only once the address enable already reads low
            next_pins.read_strobe_n = !(reading && next_state == ST_DATA && !pins.ad_oe);
            next_pins.read_strobe_oe = strap_captured;
        end
        next_pins.lock_n = !(lock_active || (start_cycle && !req.is_prefetch && lock_armed));
        next_pins.lock_oe = 1'b1;
        if (bus_granted) begin
            next_pins.ad_oe = 1'b0;
            next_pins.read_strobe_oe = 1'b0;
            next_pins.lock_oe = 1'b0;
            if (!queue_report_mode_select) begin
                next_pins.ale_qs0_oe = 1'b0;
                next_pins.write_qs1_oe = 1'b0;
            end
        end
    end

    // lock floated in reset
    // all enables drop in reset so the pull-up sets the strap level
    always_ff @(posedge clk) begin
        if (reset) begin
            pins.ale_qs0 <= 1'b0;
            pins.ale_qs0_oe <= 1'b0;
            pins.read_strobe_n <= STROBE_IDLE_LEVEL;
            pins.read_strobe_oe <= 1'b0;
            pins.write_qs1 <= STROBE_IDLE_LEVEL;
            pins.write_qs1_oe <= 1'b0;
            pins.lock_n <= 1'b1;
            pins.lock_oe <= 1'b0;
            pins.ad_oe <= 1'b0;
        end else if (clk_en) begin
            pins <= next_pins;
        end
    end

    // board keeps async ready clean or low
    // a late fall is caught two edges late; the sequencer tolerates that
    // because it leaves the data state on the first ready it sees

endmodule

// ---- brlq_pkg.sv ----
/*
 * package for the local bus control block: bus cycle request layout,
 * queue status codes, pin bundle layout and strap timing.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package brlq_pkg;

    // -------------------------------------------------------------
    // queue status codes, {queue_state_bit1, queue_state_bit0}
    // -------------------------------------------------------------
    localparam logic [1:0] QUEUE_CODE_IDLE = 2'h0;
    localparam logic [1:0] QUEUE_CODE_FIRST = 2'h1;
    localparam logic [1:0] QUEUE_CODE_NEXT = 2'h3;
    localparam logic [1:0] QUEUE_CODE_FLUSH = 2'h2;

    // -------------------------------------------------------------
    // strap capture and reset values
    // -------------------------------------------------------------
    // edges after reset release before the strap level is trusted
    localparam int STRAP_SETTLE_CYCLES = 3;
    localparam logic [1:0] STRAP_COUNT_RESET = 2'h0;
    localparam logic STROBE_IDLE_LEVEL = 1'b1;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    // queue activity reported by the execution unit each cycle
    typedef enum logic [1:0] {
        QUEUE_NONE,
        QUEUE_FIRST_BYTE,
        QUEUE_NEXT_BYTE,
        QUEUE_EMPTIED
    } brlq_queue_op_type;

    // bus cycle request from the execution unit
    typedef struct packed {
        logic is_write;
        logic is_io;
        logic is_prefetch;
    } brlq_bus_req_type;

    // control pins toward the board, each with its output enable
    typedef struct packed {
        logic ale_qs0;
        logic ale_qs0_oe;
        logic read_strobe_n;
        logic read_strobe_oe;
        logic write_qs1;
        logic write_qs1_oe;
        logic lock_n;
        logic lock_oe;
        logic ad_oe;
    } brlq_pins_type;

endpackage

// ---- brlq_bus_control_assertions.sv ----
/* concurrent checks on the local bus control block, bound to its ports.
   assumes clk_en is held high and one clock domain. */
`timescale 1ns/1ns
module brlq_bus_control_checker
    import brlq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // execution unit side
    input wire logic req_valid,
    input wire brlq_bus_req_type req,
    input wire logic req_ready,
    input wire logic prefetch_blocked,
    input wire logic cycle_done,
    input wire logic locked_instr_done,
    input wire brlq_queue_op_type queue_op,
    input wire logic bus_granted,
    // board side
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    input wire brlq_pins_type pins,
    input wire logic queue_report_mode_select,
    input wire logic strap_captured
);
    // ----------
    // properties
    // ----------
    default clocking dflt @(posedge clk); endclocking
    default disable iff (reset);

    property p_queue_code;
        queue_report_mode_select && $past(queue_report_mode_select) |->
            {pins.write_qs1, pins.ale_qs0} == {$past(queue_op[1]), ^$past(queue_op)};
    endproperty
    a_queue_code: assert property (p_queue_code) else $error("queue code wrong");
    property p_read_only;
        pins.read_strobe_oe && !pins.read_strobe_n |-> pins.write_qs1;
    endproperty
    a_read_only: assert property (p_read_only) else $error("read strobe in write");
    property p_float_first;
        $fell(pins.read_strobe_n) |-> !$past(pins.ad_oe);
    endproperty
    a_float_first: assert property (p_float_first) else $error("strobe before float");
    property p_reset_float;
        disable iff (1'b0) reset |=> !pins.lock_oe && !pins.read_strobe_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pins driven in reset");
    property p_mode_hold;
        strap_captured |=> strap_captured && $stable(queue_report_mode_select);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    property p_queue_pins;
        queue_report_mode_select && $past(queue_report_mode_select) |->
            !pins.read_strobe_oe && pins.ale_qs0_oe && pins.write_qs1_oe;
    endproperty
    a_queue_pins: assert property (p_queue_pins) else $error("queue pins not driven");
    property p_grant_float;
        bus_granted |=> !pins.read_strobe_oe && !pins.lock_oe;
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("driven in grant");
    property p_async_ready;
        pins.read_strobe_oe && !pins.read_strobe_n && async_ready_in |-> ##[1:4] cycle_done;
    endproperty
    a_async_ready: assert property (p_async_ready) else $error("async ready lost");
    property p_sync_ready;
        pins.read_strobe_oe && !pins.read_strobe_n && sync_ready_in |=> pins.read_strobe_n && cycle_done;
    endproperty
    a_sync_ready: assert property (p_sync_ready) else $error("sync ready late");
    property p_lock_start;
        $fell(pins.lock_n) |-> $past(req_valid) && $past(req_ready) && !$past(req.is_prefetch);
    endproperty
    a_lock_start: assert property (p_lock_start) else $error("lock without take");
    property p_lock_hold;
        !pins.lock_n && pins.lock_oe && !locked_instr_done && !$past(locked_instr_done) && !bus_granted
            |=> !pins.lock_n;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    property p_no_prefetch;
        prefetch_blocked && req_valid && req_ready && req.is_prefetch |=> req_ready && !cycle_done;
    endproperty
    a_no_prefetch: assert property (p_no_prefetch) else $error("prefetch taken");
endmodule

bind brlq_bus_control brlq_bus_control_checker i_checker (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .prefetch_blocked(prefetch_blocked), .cycle_done(cycle_done),
    .locked_instr_done(locked_instr_done), .queue_op(queue_op), .bus_granted(bus_granted),
    .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in), .pins(pins),
    .queue_report_mode_select(queue_report_mode_select), .strap_captured(strap_captured));

// ---- brlq_mem_model.sv ----
/* memory or i/o device on the far side: answers strobes with ready after
   a set number of wait states. assumes normal strobe mode during cycles. */
`timescale 1ns/1ns
module brlq_mem_model
    import brlq_pkg::*;
(
    // bus pins
    input wire logic clk,
    input wire brlq_pins_type pins,
    // bench controls; 4'hf holds ready high for good
    input wire logic [3:0] wait_count,
    input wire logic use_async,
    // ready answers
    output logic sync_ready_in,
    output logic async_ready_in
);
    logic [3:0] waited;
    logic strobing;
    logic steady;

    // a strobe counts only while it is driven low
    assign strobing = (pins.read_strobe_oe && !pins.read_strobe_n) || (pins.write_qs1_oe && !pins.write_qs1);
    assign steady = wait_count == 4'hf;

    // pace the wait states
    always_ff @(posedge clk) begin
        waited <= strobing ? waited + 4'h1 : 4'h0;
    end

    assign sync_ready_in = !use_async && (steady || (strobing && waited >= wait_count));

    // async: rises off-clock, falls on clock
    initial async_ready_in = 1'b0;
    always @(posedge clk) begin
        if (use_async && steady) begin
            async_ready_in <= 1'b1;
        end else if (!strobing) begin
            async_ready_in <= 1'b0;
        end else if (use_async && waited >= wait_count) begin
            async_ready_in <= #7 1'b1; // mid-cycle on purpose
        end
    end
endmodule

// ---- brlq_bus_control_test.sv ----
/* self-checking bench for the local bus control block: bus cycles from a
   table, then lock, grant, reset and queue status cases.
   assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ns
module brlq_bus_control_test;
    import brlq_pkg::*;

    // request, waits, ready path, edges from take to done
    typedef struct packed {
        brlq_bus_req_type rq;
        logic [3:0] waits;
        logic asy;
        logic [7:0] edges;
    } brlq_row_type;

    logic clk, reset, clk_en, req_valid, req_ready, prefetch_blocked, cycle_done;
    logic lock_prefix_seen, locked_instr_done, bus_granted, strap_pin, strap_ground;
    logic async_ready_in, sync_ready_in, use_async, mode, strap_captured;
    logic [3:0] wait_count;
    brlq_bus_req_type req;
    brlq_queue_op_type queue_op;
    brlq_pins_type pins;
    int num_errors = 0;
    int num_checks = 0;
    brlq_row_type rows [8] = '{'{3'h0, 4'h0, 1'b0, 8'h04}, '{3'h4, 4'h0, 1'b0, 8'h04},
        '{3'h2, 4'h2, 1'b0, 8'h06}, '{3'h6, 4'h3, 1'b0, 8'h07}, '{3'h1, 4'h0, 1'b1, 8'h07},
        '{3'h0, 4'h1, 1'b1, 8'h08}, '{3'h0, 4'hf, 1'b0, 8'h04}, '{3'h4, 4'hf, 1'b1, 8'h04}};
    logic [1:0] codes [4] = '{QUEUE_CODE_IDLE, QUEUE_CODE_FIRST, QUEUE_CODE_NEXT, QUEUE_CODE_FLUSH};

    always #25 clk = ~clk;

    assign strap_pin = pins.read_strobe_oe ? pins.read_strobe_n : !strap_ground;

    brlq_bus_control i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .prefetch_blocked(prefetch_blocked), .cycle_done(cycle_done),
        .lock_prefix_seen(lock_prefix_seen), .locked_instr_done(locked_instr_done), .queue_op(queue_op),
        .bus_granted(bus_granted), .read_strobe_mode_strap(strap_pin), .async_ready_in(async_ready_in),
        .sync_ready_in(sync_ready_in), .pins(pins), .queue_report_mode_select(mode),
        .strap_captured(strap_captured));
    brlq_mem_model i_mem (.clk(clk), .pins(pins), .wait_count(wait_count), .use_async(use_async),
        .sync_ready_in(sync_ready_in), .async_ready_in(async_ready_in));

    // -----
    // tasks
    // -----
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset with the strap pin pulled up or grounded
    task automatic do_reset(input logic gnd);
        strap_ground = gnd;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        check(8'(pins.read_strobe_oe), 8'h0);
        reset = 1'b0;
        repeat (6) @(negedge clk);
        check(8'(strap_captured), 8'h1);
        check(8'(mode), 8'(gnd));
    endtask

    // one request, raised once ready is seen and held for one edge, then edges counted to done
    task automatic bus_cycle(input brlq_bus_req_type rq, input logic [7:0] edges);
        logic [7:0] n;
        while (req_ready !== 1'b1) @(negedge clk);
        req = rq;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        n = 8'h1;
        while (cycle_done !== 1'b1 && n < 8'h28) begin
            @(negedge clk);
            n = n + 8'h1;
        end
        check(n, edges);
    endtask

    // -------------
    // main sequence
    // -------------
    initial begin
        clk = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = 3'h0;
        lock_prefix_seen = 1'b0;
        locked_instr_done = 1'b0;
        queue_op = QUEUE_NONE;
        bus_granted = 1'b0;
        wait_count = 4'h0;
        use_async = 1'b0;
        do_reset(1'b0);
        foreach (rows[i]) begin
            wait_count = rows[i].waits;
            use_async = rows[i].asy;
            bus_cycle(rows[i].rq, rows[i].edges);
        end
        wait_count = 4'h0;
        use_async = 1'b0;
        // prefix, prefetch first: lock waits for the data cycle
        lock_prefix_seen = 1'b1;
        @(negedge clk);
        lock_prefix_seen = 1'b0;
        bus_cycle(3'h1, 8'h04);
        check(8'(pins.lock_n), 8'h1);
        bus_cycle(3'h0, 8'h04);
        check(8'({pins.lock_n, pins.lock_oe, prefetch_blocked}), 8'h3);
        req = 3'h1;
        req_valid = 1'b1;
        repeat (5) @(negedge clk);
        check(8'({req_ready, cycle_done}), 8'h2);
        req_valid = 1'b0;
        locked_instr_done = 1'b1;
        @(negedge clk);
        locked_instr_done = 1'b0;
        @(negedge clk);
        check(8'(pins.lock_n), 8'h1);
        // bus handed away and back
        bus_granted = 1'b1;
        repeat (2) @(negedge clk);
        check(8'({pins.read_strobe_oe, pins.lock_oe, req_ready, pins.ad_oe}), 8'h0);
        bus_granted = 1'b0;
        repeat (2) @(negedge clk);
        check(8'(pins.lock_oe), 8'h1);
        // grounded strap: queue status on the latch and write pins
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) begin
            queue_op = brlq_queue_op_type'(i[1:0]);
            repeat (2) @(negedge clk);
            check(8'({pins.write_qs1, pins.ale_qs0}), 8'(codes[i]));
            check(8'({pins.read_strobe_oe, pins.ale_qs0_oe}), 8'h1);
        end
        end_sim;
    end

    // hang guard, far above the hundred or so cycles needed
    initial begin
        #(3000 * 50);
        num_errors++;
        end_sim;
    end
endmodule
